// file: wdru_pkg.sv
// Package for the watchdog reload and unlock block
package wdru_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h0FF0;
  localparam logic [ADDR_W-1:0] OFF_RELU = 12'h0FF4;
  localparam logic [ADDR_W-1:0] OFF_RELH = 12'h0FF8;
  localparam logic [ADDR_W-1:0] OFF_RELL = 12'h0FFC;
  localparam logic [ADDR_W-1:0] OFF_CFG = 12'h0FE0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h0FE4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h0FE8;
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [23:0] RELOAD_RST = 24'hFF_FFFF;
  localparam logic [23:0] RELOAD_MIN = 24'h00_0004;
  localparam int IPO_CYC_NOXTAL = 66;
  localparam int IPO_CYC_XTAL = 5000;
  localparam int IPO_DIV_DEFAULT = 4;
  // Reset status layout
  localparam int BIT_WDT_TO = 5;
  localparam int BIT_EXT = 4;
  localparam int BIT_SMR = 3;
  // Interrupt status layout
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_UNLOCK_ERR = 1;
  localparam int IRQ_W = 2;
  // Config layout
  localparam int CFG_RESET_OPT = 0;
  localparam int CFG_XTAL_EN = 1;
  localparam int CFG_STOP = 2;
  localparam int CFG_RUN = 3;
  localparam logic [7:0] CFG_RST = 8'h08;
  typedef enum logic [2:0]
  {
    UL_IDLE = 3'b001,
    UL_HALF = 3'b010,
    UL_OPEN = 3'b100
  } wdru_unlock_e;
endpackage : wdru_pkg

// file: wdru_hold_timer.sv
// Reset-hold counter for stop-mode recovery and system reset
`timescale 1ns/100ps
module wdru_hold_timer #(
  parameter int CNT_W = 13
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic [CNT_W-1:0] cycles,
  output logic busy
);
  typedef struct packed
  {
    logic [CNT_W-1:0] cnt;
    logic busy;
  } wdru_hold_s;
  wdru_hold_s st_q;
  wdru_hold_s st_d;
  always_comb
  begin
    st_d = st_q;
    if (start)
    begin
      st_d.cnt = cycles;
      st_d.busy = 1'b1;
    end
    else if (st_q.busy && tick)
    begin
      if (st_q.cnt <= CNT_W'(1))
      begin
        st_d.busy = 1'b0;
        st_d.cnt = '0;
      end
      else
        st_d.cnt = st_q.cnt - CNT_W'(1);
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign busy = st_q.busy;
endmodule : wdru_hold_timer

// file: wdru_watchdog.sv
// Watchdog reload registers, unlock sequence and reset status
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
module wdru_watchdog
  import wdru_pkg::*;
#(
  parameter int IPO_DIV = wdru_pkg::IPO_DIV_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [wdru_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [wdru_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [wdru_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic refreshInstr,
  input wire logic extResetPin_n,
  output logic sysResetReq,
  output logic coreHold,
  output logic oscCtrlReinit,
  output logic irq
);
  import wdru_pkg::*;

  typedef struct packed
  {
    wdru_unlock_e ul;
    logic [23:0] reload;
    logic [23:0] count;
    logic [7:0] reset_status_reg;
    logic [7:0] cfg;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [15:0] div;
    logic sysRst;
    logic oscReinit;
    logic pinSeen;
  } wdru_state_s;

  wdru_state_s st_q;
  wdru_state_s st_d;
  logic [1:0] pinSync_q;
  logic tick;
  logic timeout;
  logic holdStart;
  logic [12:0] holdCycles;
  logic holdBusy;
  logic wrAcc;
  logic rdAcc;

  // Pin is asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pinSync_q <= 2'b11;
    else
      pinSync_q <= {pinSync_q[0], extResetPin_n};
  end

  assign tick = (st_q.div == 16'(IPO_DIV - 1));
  assign timeout = tick && (st_q.count == 24'h00_0000) && st_q.cfg[CFG_RUN];
  // One wait state; a write lands on the edge where waitrequest is low
  assign wrAcc = avs_write && st_q.ack;
  assign rdAcc = avs_read && !st_q.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;

  always_comb
  begin
    logic [IRQ_W-1:0] irqSet;
    irqSet = '0;
    st_d = st_q;
    st_d.ack = (avs_read || avs_write) && !st_q.ack;
    st_d.sysRst = 1'b0;
    st_d.oscReinit = 1'b0;
    st_d.div = tick ? 16'h0000 : st_q.div + 16'h0001;
    holdStart = 1'b0;
    holdCycles = st_q.cfg[CFG_XTAL_EN] ? 13'(IPO_CYC_XTAL) : 13'(IPO_CYC_NOXTAL);
    if (tick && st_q.cfg[CFG_RUN] && st_q.count != 24'h00_0000)
      st_d.count = st_q.count - 24'h00_0001;
    if (refreshInstr)
      st_d.count = st_q.reload;
    if (timeout)
    begin
      irqSet[IRQ_TIMEOUT] = 1'b1;
      st_d.reset_status_reg[BIT_WDT_TO] = 1'b1;
      st_d.count = st_q.reload;
      if (st_q.cfg[CFG_STOP])
      begin
        st_d.cfg[CFG_STOP] = 1'b0;
        st_d.reset_status_reg[BIT_SMR] = 1'b1;
        st_d.ul = UL_IDLE;
        st_d.oscReinit = 1'b1;
        holdStart = 1'b1;
      end
      else if (st_q.cfg[CFG_RESET_OPT])
      begin
        st_d.sysRst = 1'b1;
        holdStart = 1'b1;
      end
    end
    st_d.pinSeen = !pinSync_q[1];
    if (pinSync_q[1] && st_q.pinSeen)
    begin
      st_d.reset_status_reg[BIT_EXT] = 1'b1;
      st_d.ul = UL_IDLE;
      holdStart = 1'b1;
    end
    if (wrAcc && avs_byteenable[0])
    begin
      case (avs_address)
        OFF_CTRL:
        begin
          // Step unlock; only the unlock state and, on a wrong second byte, the unlock-error flag change
          case (st_q.ul)
            UL_IDLE: st_d.ul = (avs_writedata[7:0] == UNLOCK_FIRST) ? UL_HALF : UL_IDLE;
            UL_HALF:
            begin
              if (avs_writedata[7:0] == UNLOCK_SECOND)
                st_d.ul = UL_OPEN;
              else
              begin
                st_d.ul = UL_IDLE;
                irqSet[IRQ_UNLOCK_ERR] = 1'b1;
              end
            end
            UL_OPEN: st_d.ul = (avs_writedata[7:0] == UNLOCK_FIRST) ? UL_HALF : UL_IDLE;
            default: st_d.ul = UL_IDLE;
          endcase
        end
        OFF_RELU: if (st_q.ul == UL_OPEN) st_d.reload[23:16] = avs_writedata[7:0];
        OFF_RELH: if (st_q.ul == UL_OPEN) st_d.reload[15:8] = avs_writedata[7:0];
        OFF_RELL: if (st_q.ul == UL_OPEN) st_d.reload[7:0] = avs_writedata[7:0];
        OFF_CFG: st_d.cfg = avs_writedata[7:0];
        OFF_IRQ_STAT: st_d.irqStat = st_q.irqStat & ~avs_writedata[IRQ_W-1:0];
        OFF_IRQ_MASK: st_d.irqMask = avs_writedata[IRQ_W-1:0];
        default: st_d.ul = st_q.ul;
      endcase
    end
    // Set wins over clear
    st_d.irqStat = st_d.irqStat | irqSet;
    if (rdAcc)
    begin
      case (avs_address)
        OFF_CTRL: st_d.rdata = {24'h00_0000, st_q.reset_status_reg};
        OFF_RELU: st_d.rdata = {24'h00_0000, st_q.count[23:16]};
        OFF_RELH: st_d.rdata = {24'h00_0000, st_q.count[15:8]};
        OFF_RELL: st_d.rdata = {24'h00_0000, st_q.count[7:0]};
        OFF_CFG: st_d.rdata = {24'h00_0000, st_q.cfg};
        OFF_IRQ_STAT: st_d.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_q.irqStat};
        OFF_IRQ_MASK: st_d.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_q.irqMask};
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
      st_q.ul <= UL_IDLE;
      st_q.reload <= RELOAD_RST;
      st_q.count <= RELOAD_RST;
      st_q.cfg <= CFG_RST;
    end
    else
      st_q <= st_d;
  end

  wdru_hold_timer #(
    .CNT_W(13)
  ) u_hold (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(tick),
    .start(holdStart),
    .cycles(holdCycles),
    .busy(holdBusy)
  );

  assign avs_readdata = st_q.rdata;
  assign sysResetReq = st_q.sysRst;
  assign oscCtrlReinit = st_q.oscReinit;
  assign coreHold = holdBusy;
  assign irq = |(st_q.irqStat & st_q.irqMask);

  // Checks
  a_reload_locked: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wrAcc && avs_address == OFF_RELL && st_q.ul != UL_OPEN) |=> $stable(st_q.reload[7:0]))
    else $error("reload changed while locked");
  a_reload_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wrAcc && avs_byteenable[0] && avs_address == OFF_RELH && st_q.ul == UL_OPEN)
    |=> st_q.reload[15:8] == $past(avs_writedata[7:0]))
    else $error("reload high byte not written");
  a_unlock_seq: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wrAcc && avs_byteenable[0] && avs_address == OFF_CTRL && st_q.ul == UL_HALF
     && avs_writedata[7:0] == UNLOCK_SECOND) |=> st_q.ul == UL_OPEN)
    else $error("unlock not opened");
  a_unlock_relock: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (wrAcc && avs_byteenable[0] && avs_address == OFF_CTRL && st_q.ul == UL_HALF
     && avs_writedata[7:0] != UNLOCK_SECOND && !holdStart) |=> st_q.ul == UL_IDLE)
    else $error("wrong byte did not relock");
  a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rdAcc && avs_address == OFF_CTRL) |=> avs_readdata[7:0] == $past(st_q.reset_status_reg))
    else $error("control read not status");
  a_count_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rdAcc && avs_address == OFF_RELU) |=> avs_readdata[7:0] == $past(st_q.count[23:16]))
    else $error("upper read not count");
  a_refresh_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (refreshInstr && !timeout) |=> st_q.count == $past(st_q.reload))
    else $error("refresh did not load");
  a_reset_option: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (timeout && !st_q.cfg[CFG_RESET_OPT]) |=> !sysResetReq)
    else $error("reset without option");
  a_stop_wake: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (timeout && st_q.cfg[CFG_STOP]) |=> ##1 coreHold && oscCtrlReinit == 1'b0)
    else $error("no recovery from stop");
  c_unlock: cover property (@(posedge clk_sys) disable iff (!arst_n) st_q.ul == UL_OPEN);
  c_timeout: cover property (@(posedge clk_sys) disable iff (!arst_n) timeout);
  c_irq: cover property (@(posedge clk_sys) disable iff (!arst_n) irq);
endmodule : wdru_watchdog

// file: wdru_tb.sv
// Self-checking bench for the watchdog reload and unlock block
`timescale 1ns/100ps
module testbench;
  import wdru_pkg::*;
  logic clk_sys = 0, arst_n = 0, rd = 0, wr = 0, refreshInstr = 0, extResetPin_n = 1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic waitReq, sysResetReq, coreHold, oscCtrlReinit, irq;
  logic [63:0] expQ[$];
  logic [63:0] cur;
  logic [23:0] rv;
  int n_mismatch = 0, check_count = 0, seed = 21, n, seen;

  // Oscillator tick every clock keeps the hold counts short
  wdru_watchdog #(.IPO_DIV(1)) wdru_watchdog_inst (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .refreshInstr(refreshInstr), .extResetPin_n(extResetPin_n),
    .sysResetReq(sysResetReq), .coreHold(coreHold), .oscCtrlReinit(oscCtrlReinit), .irq(irq));

  initial forever #2 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Holds the request until waitrequest is seen low before an edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(negedge clk_sys);
      k++;
    end while (waitReq !== 1'b0 && k < 50);
    if (k >= 50) begin n_mismatch++; final_report(); end
    @(posedge clk_sys);
    rd <= 0;
    wr <= 0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rdx(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    expQ.push_back({m, e});
    bus(0, a, 0);
  endtask : rdx

  task automatic setRel(input logic [23:0] v);
    bus(1, OFF_RELU, v[23:16]);
    bus(1, OFF_RELH, v[15:8]);
    bus(1, OFF_RELL, v[7:0]);
  endtask : setRel

  // Counter is stopped, so the live count equals the loaded value
  task automatic chkRel(input logic [23:0] v);
    refreshInstr <= 1;
    @(posedge clk_sys);
    refreshInstr <= 0;
    @(posedge clk_sys);
    rdx(OFF_RELU, 32'hFF, v[23:16]);
    rdx(OFF_RELH, 32'hFF, v[15:8]);
    rdx(OFF_RELL, 32'hFF, v[7:0]);
  endtask : chkRel

  task automatic endTest(input string s);
    $display("test %0s done at %0t", s, $time);
  endtask : endTest

  // Read data stand in the cycle where waitrequest is low
  always @(negedge clk_sys)
    if (rd && waitReq === 1'b0)
    begin
      cur = expQ.pop_front();
      chk(rdata & cur[63:32], cur[31:0]);
    end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1;
    bus(1, OFF_CFG, 0);
    rdx(OFF_CTRL, 32'h38, 0);
    rv = $random(seed);
    setRel(rv);
    chkRel(24'hFF_FFFF);
    rdx(12'h0100, 32'hFFFF_FFFF, 0);
    endTest("locked");
    bus(1, OFF_CTRL, UNLOCK_FIRST);
    bus(1, OFF_CTRL, UNLOCK_SECOND);
    rdx(OFF_CTRL, 32'h38, 0);
    rv = $random(seed) | 24'h00_0004;
    setRel(rv);
    chkRel(rv);
    endTest("unlock");
    bus(1, OFF_IRQ_MASK, 2);
    bus(1, OFF_CTRL, UNLOCK_FIRST);
    bus(1, OFF_CTRL, 8'h00);
    chk(irq, 1);
    rdx(OFF_IRQ_STAT, 32'h3, 32'h2);
    setRel(~rv);
    chkRel(rv);
    bus(1, OFF_IRQ_STAT, 2);
    chk(irq, 0);
    bus(1, OFF_IRQ_MASK, 0);
    bus(1, OFF_CTRL, UNLOCK_FIRST);
    bus(1, OFF_CTRL, 8'h11);
    chk(irq, 0);
    rdx(OFF_IRQ_STAT, 32'h2, 32'h2);
    bus(1, OFF_IRQ_STAT, 2);
    endTest("relock");
    bus(1, OFF_CTRL, UNLOCK_FIRST);
    bus(1, OFF_CTRL, UNLOCK_SECOND);
    setRel(RELOAD_MIN);
    chkRel(RELOAD_MIN);
    bus(1, OFF_CFG, 8'h08);
    n = 0;
    repeat (60)
    begin
      @(negedge clk_sys);
      if (sysResetReq === 1'b1) n++;
    end
    chk(n, 0);
    rdx(OFF_IRQ_STAT, 32'h1, 32'h1);
    bus(1, OFF_CFG, 8'h09);
    n = 0;
    while (sysResetReq !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(sysResetReq, 1);
    bus(1, OFF_CFG, 0);
    rdx(OFF_CTRL, 32'h20, 32'h20);
    endTest("timeout");
    for (int i = 0; i < 2; i++)
    begin
      seen = 0;
      // Let the previous hold run out first
      repeat (80) @(posedge clk_sys);
      bus(1, OFF_CFG, i ? 8'h0E : 8'h0C);
      n = 0;
      while (coreHold !== 1'b1 && n < 200)
      begin
        @(negedge clk_sys);
        seen |= oscCtrlReinit;
        n++;
      end
      n = 0;
      while (coreHold === 1'b1 && n < 6000)
      begin
        @(negedge clk_sys);
        seen |= oscCtrlReinit;
        n++;
      end
      chk(n, i ? IPO_CYC_XTAL : IPO_CYC_NOXTAL);
      chk(seen, 1);
      bus(1, OFF_CFG, 0);
    end
    rdx(OFF_CTRL, 32'h08, 32'h08);
    rv = $random(seed);
    setRel(rv);
    chkRel(RELOAD_MIN);
    endTest("stop recovery");
    extResetPin_n <= 0;
    repeat (8) @(posedge clk_sys);
    extResetPin_n <= 1;
    repeat (80) @(posedge clk_sys);
    rdx(OFF_CTRL, 32'h10, 32'h10);
    endTest("pin reset");
    final_report();
  end
endmodule : testbench
